// ==== shared/sisr_pkg.sv ====
// Package for the S interface status reporter: status codes, event indices and carriers
// Notes on behaviour
// - Far-end line signal reports code 0x02
// - Activation pending on INFO frames reports 0x03
// - TE message-sent reports 0x06, host can disable
// - Echo mismatch during transmit reports lost collision 0x07
// - Activation complete reports code 0x0c
// - Frame alignment loss reports code 0x0e
// - Multiframe tick 0x04 every 5 or 30 ms
// - SC1/Q message reports 0011 plus message bits
// - SC2 message reports 0101 plus message bits
// - Receive multiframe fault reports code 0x05
// - Fault and slip events need extra-events command
// - Slip codes 0x09 tx, 0x0a rx, 0x0b both
// - Buffer phase change raises a slip event
// - No change with state off returns zero
// - No change with state on returns 1,state,0000
// - State output is off after reset
// - Interrupt low only while select high, cleared on select
// - One latch per source, circular order, overwrite repeats
// - Deactivated clears pending; far-end valid only in low power
package sisr_pkg;
  localparam int SISR_NUM_EVT = 12;
  localparam int SISR_IDX_W = 4;
  // Event latch indices, also the circular scan order
  localparam logic [3:0] SISR_EV_FAR = 4'h0;
  localparam logic [3:0] SISR_EV_APEND = 4'h1;
  localparam logic [3:0] SISR_EV_ADONE = 4'h2;
  localparam logic [3:0] SISR_EV_FSLOSS = 4'h3;
  localparam logic [3:0] SISR_EV_DEACT = 4'h4;
  localparam logic [3:0] SISR_EV_SENT = 4'h5;
  localparam logic [3:0] SISR_EV_COLL = 4'h6;
  localparam logic [3:0] SISR_EV_SC1Q = 4'h7;
  localparam logic [3:0] SISR_EV_SC2 = 4'h8;
  localparam logic [3:0] SISR_EV_TICK = 4'h9;
  localparam logic [3:0] SISR_EV_FAULT = 4'ha;
  localparam logic [3:0] SISR_EV_SLIP = 4'hb;
  // Status codes
  localparam logic [7:0] SISR_CODE_FAR = 8'h02;
  localparam logic [7:0] SISR_CODE_APEND = 8'h03;
  localparam logic [7:0] SISR_CODE_ADONE = 8'h0c;
  localparam logic [7:0] SISR_CODE_FSLOSS = 8'h0e;
  localparam logic [7:0] SISR_CODE_DEACT = 8'h0f;
  localparam logic [7:0] SISR_CODE_SENT = 8'h06;
  localparam logic [7:0] SISR_CODE_COLL = 8'h07;
  localparam logic [7:0] SISR_CODE_TICK = 8'h04;
  localparam logic [7:0] SISR_CODE_FAULT = 8'h05;
  localparam logic [7:0] SISR_CODE_SLIP_TX = 8'h09;
  localparam logic [7:0] SISR_CODE_SLIP_RX = 8'h0a;
  localparam logic [7:0] SISR_CODE_SLIP_BOTH = 8'h0b;
  localparam logic [3:0] SISR_HI_SC1Q = 4'h3;
  localparam logic [3:0] SISR_HI_SC2 = 4'h5;
  localparam logic [7:0] SISR_NO_CHANGE_CODE = 8'h00;
  localparam logic [0:0] SISR_NO_CHANGE_WITH_STATE_MARK = 1'h1;
  // Commands that steer this block
  localparam logic [7:0] SISR_IDLE_CMD = 8'hff;
  localparam logic [7:0] SISR_LOW_POWER_CMD = 8'h00;
  localparam logic [7:0] SISR_WAKE_CMD = 8'h20;
  localparam logic [7:0] SISR_SENT_ON_CMD = 8'h10;
  localparam logic [7:0] SISR_SENT_OFF_CMD = 8'h11;
  localparam logic [7:0] SISR_TICK_5MS_ON_CMD = 8'h22;
  localparam logic [7:0] SISR_TICK_5MS_OFF_CMD = 8'h23;
  localparam logic [7:0] SISR_TICK_30MS_ON_CMD = 8'h24;
  localparam logic [7:0] SISR_TICK_30MS_OFF_CMD = 8'h25;
  localparam logic [7:0] SISR_STATE_OUT_ON_CMD = 8'h92;
  localparam logic [7:0] SISR_STATE_OUT_OFF_CMD = 8'h93;
  localparam logic [7:0] SISR_EXTRA_EVENTS_ON_CMD = 8'h94;
  localparam logic [7:0] SISR_EXTRA_EVENTS_OFF_CMD = 8'h95;
  localparam int SISR_TICKS_PER_30MS = 6;
  localparam int SISR_BITS_PER_XFER = 8;

  typedef struct packed {
    logic far_end_signal_seen;
    logic activation_pending_evt;
    logic activation_done_evt;
    logic frame_sync_loss_evt;
    logic deactivated_evt;
    logic d_msg_sent_evt;
    logic lost_collision_evt;
    logic sc1q_msg_rx_evt;
    logic sc2_msg_rx_evt;
    logic multiframe_boundary;
    logic rx_multiframe_fault_evt;
    logic slip_tx_evt;
    logic slip_rx_evt;
    logic [3:0] message_nibble_bits;
  } sisr_evt_t;

  typedef struct packed {
    logic [7:0] cmd;
    logic valid;
  } sisr_cmd_t;
endpackage : sisr_pkg

// ==== rtl/sisr_sync.sv ====
// Three-stage synchroniser with agreement on the last two stages
`timescale 1ns/10ps
module sisr_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Data
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change counts once the last two stages agree
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_sync <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          o_sync[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule : sisr_sync

// ==== rtl/sisr_shift_port.sv ====
// Serial control port shifter on the control serial clock
`timescale 1ns/10ps
module sisr_shift_port
  import sisr_pkg::*;
(
  // Serial control clock and reset
  input wire logic i_ctl_serial_clock,
  input wire logic i_reset_n,
  // Serial pins
  input wire logic i_cs_n,
  input wire logic i_cmd_in,
  output logic o_status_out,
  output logic o_status_out_en,
  // Status byte, held stable by the core while select is low
  input wire logic [7:0] i_status_byte,
  // Command word and toggle telling a transfer finished
  output logic [7:0] o_cmd_word,
  output logic o_done_toggle,
  // Toggle at the first rising edge of a transfer
  output logic o_start_toggle
);
  logic [7:0] in_reg;
  logic [7:0] out_reg;
  logic [2:0] cnt_reg;
  logic first_reg;
  logic frame_rst_n;

  // Command in on rising edges; start and done are flagged by toggles
  always_ff @(posedge i_ctl_serial_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      in_reg <= 8'h00;
      cnt_reg <= 3'h0;
      o_cmd_word <= SISR_IDLE_CMD;
      o_done_toggle <= 1'b0;
      o_start_toggle <= 1'b0;
    end else if (!i_cs_n) begin
      in_reg <= {in_reg[6:0], i_cmd_in};
      cnt_reg <= cnt_reg + 3'h1;
      if (cnt_reg == 3'h0) begin
        o_start_toggle <= ~o_start_toggle;
      end
      if (cnt_reg == 3'(SISR_BITS_PER_XFER - 1)) begin
        o_cmd_word <= {in_reg[6:0], i_cmd_in};
        o_done_toggle <= ~o_done_toggle;
      end
    end
  end

  // Status out on falling edges, bit 7 first
  always_ff @(negedge i_ctl_serial_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      out_reg <= 8'h00;
    end else if (!i_cs_n) begin
      out_reg <= first_reg ? {i_status_byte[6:0], 1'b0} : {out_reg[6:0], 1'b0};
    end
  end

  // Select high rearms the first bit, since the serial clock stands still between frames
  assign frame_rst_n = i_reset_n & ~i_cs_n;

  always_ff @(negedge i_ctl_serial_clock or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      first_reg <= 1'b1;
    end else begin
      first_reg <= 1'b0;
    end
  end

  assign o_status_out = first_reg ? i_status_byte[7] : out_reg[7];
  assign o_status_out_en = ~i_cs_n;
endmodule : sisr_shift_port

// ==== rtl/sisr_core.sv ====
// Status and interrupt reporting unit of the S interface transceiver
`timescale 1ns/10ps
module sisr_core
  import sisr_pkg::*;
(
  // System clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Serial control port
  input wire logic i_ctl_serial_clock,
  input wire logic i_cs_n,
  input wire logic i_cmd_in,
  output logic o_status_out,
  output logic o_status_out_en,
  output logic o_int_n,
  output logic o_int_n_en,
  // Event sources, one-cycle pulses on i_clk
  input wire sisr_pkg::sisr_evt_t i_evt,
  input wire logic i_te_mode,
  input wire logic [2:0] i_device_state_field,
  // Command word seen by the rest of the device
  output sisr_pkg::sisr_cmd_t o_cmd,
  // Mode flags for the rest of the device
  output logic o_low_power,
  output logic o_extra_events_on
);
  import sisr_pkg::*;

  logic [7:0] cmd_word;
  logic done_tgl;
  logic start_tgl;
  logic [2:0] x_sync;
  logic done_seen_reg;
  logic start_seen_reg;
  logic cs_n_sync;
  logic [SISR_NUM_EVT-1:0] pend_reg;
  logic [SISR_NUM_EVT-1:0] set_vec;
  logic [3:0] sc1q_bits_reg;
  logic [3:0] sc2_bits_reg;
  logic [1:0] slip_kind_reg;
  logic [SISR_IDX_W-1:0] ptr_reg;
  logic [SISR_IDX_W-1:0] sel_idx;
  logic sel_valid;
  logic [7:0] status_reg;
  logic rep_valid_reg;
  logic [SISR_IDX_W-1:0] rep_idx_reg;
  logic busy_reg;
  logic int_reg;
  logic state_out_reg;
  logic extra_reg;
  logic sent_on_reg;
  logic tick5_reg;
  logic tick30_reg;
  logic low_power_reg;
  logic [2:0] tick_cnt_reg;
  logic cmd_pulse;
  logic start_pulse;
  logic tick_fire;

  sisr_shift_port u_port (
    .i_ctl_serial_clock(i_ctl_serial_clock),
    .i_reset_n(i_reset_n),
    .i_cs_n(i_cs_n),
    .i_cmd_in(i_cmd_in),
    .o_status_out(o_status_out),
    .o_status_out_en(o_status_out_en),
    .i_status_byte(status_reg),
    .o_cmd_word(cmd_word),
    .o_done_toggle(done_tgl),
    .o_start_toggle(start_tgl)
  );

  sisr_sync #(.WIDTH(3)) u_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async({i_cs_n, start_tgl, done_tgl}),
    .o_sync(x_sync)
  );

  assign cs_n_sync = x_sync[2];
  assign start_pulse = x_sync[1] ^ start_seen_reg;
  assign cmd_pulse = x_sync[0] ^ done_seen_reg;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      start_seen_reg <= 1'b0;
      done_seen_reg <= 1'b0;
    end else begin
      start_seen_reg <= x_sync[1];
      done_seen_reg <= x_sync[0];
    end
  end

  // Command word is stable well after its toggle is seen
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_cmd <= '{cmd: SISR_IDLE_CMD, valid: 1'b0};
    end else begin
      o_cmd.valid <= cmd_pulse;
      if (cmd_pulse) begin
        o_cmd.cmd <= cmd_word;
      end
    end
  end

  // Mode flags steered by commands
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_out_reg <= 1'b0;
      extra_reg <= 1'b0;
      sent_on_reg <= 1'b1;
      tick5_reg <= 1'b0;
      tick30_reg <= 1'b0;
      low_power_reg <= 1'b0;
    end else if (cmd_pulse) begin
      case (cmd_word)
        SISR_STATE_OUT_ON_CMD: state_out_reg <= 1'b1;
        SISR_STATE_OUT_OFF_CMD: state_out_reg <= 1'b0;
        SISR_EXTRA_EVENTS_ON_CMD: extra_reg <= 1'b1;
        SISR_EXTRA_EVENTS_OFF_CMD: extra_reg <= 1'b0;
        SISR_SENT_ON_CMD: sent_on_reg <= 1'b1;
        SISR_SENT_OFF_CMD: sent_on_reg <= 1'b0;
        SISR_TICK_5MS_ON_CMD: tick5_reg <= 1'b1;
        SISR_TICK_5MS_OFF_CMD: tick5_reg <= 1'b0;
        SISR_TICK_30MS_ON_CMD: tick30_reg <= 1'b1;
        SISR_TICK_30MS_OFF_CMD: tick30_reg <= 1'b0;
        SISR_LOW_POWER_CMD: low_power_reg <= 1'b1;
        SISR_WAKE_CMD: low_power_reg <= 1'b0;
        default: low_power_reg <= low_power_reg;
      endcase
    end
  end

  // Six-boundary divider for the 30 ms tick
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_cnt_reg <= 3'h0;
    end else if (i_evt.multiframe_boundary) begin
      if (tick_cnt_reg == 3'(SISR_TICKS_PER_30MS - 1)) begin
        tick_cnt_reg <= 3'h0;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 3'h1;
      end
    end
  end

  assign tick_fire = i_evt.multiframe_boundary &&
    (tick5_reg || (tick30_reg && tick_cnt_reg == 3'(SISR_TICKS_PER_30MS - 1)));

  // Event qualification into latch set requests
  always_comb begin
    set_vec = '0;
    set_vec[SISR_EV_FAR] = i_evt.far_end_signal_seen && low_power_reg;
    set_vec[SISR_EV_APEND] = i_evt.activation_pending_evt;
    set_vec[SISR_EV_ADONE] = i_evt.activation_done_evt;
    set_vec[SISR_EV_FSLOSS] = i_evt.frame_sync_loss_evt;
    set_vec[SISR_EV_DEACT] = i_evt.deactivated_evt;
    set_vec[SISR_EV_SENT] = i_evt.d_msg_sent_evt && i_te_mode && sent_on_reg;
    set_vec[SISR_EV_COLL] = i_evt.lost_collision_evt;
    set_vec[SISR_EV_SC1Q] = i_evt.sc1q_msg_rx_evt;
    set_vec[SISR_EV_SC2] = i_evt.sc2_msg_rx_evt;
    set_vec[SISR_EV_TICK] = tick_fire;
    set_vec[SISR_EV_FAULT] = i_evt.rx_multiframe_fault_evt && extra_reg;
    set_vec[SISR_EV_SLIP] = (i_evt.slip_tx_evt || i_evt.slip_rx_evt) && extra_reg;
  end

  // Circular search from the pointer, no priority
  always_comb begin
    logic [SISR_IDX_W:0] k;
    k = '0;
    sel_idx = '0;
    sel_valid = 1'b0;
    for (int i = SISR_NUM_EVT - 1; i >= 0; i--) begin
      k = {1'b0, ptr_reg} + (SISR_IDX_W + 1)'(i);
      if (k >= (SISR_IDX_W + 1)'(SISR_NUM_EVT)) begin
        k = k - (SISR_IDX_W + 1)'(SISR_NUM_EVT);
      end
      if (pend_reg[k[SISR_IDX_W-1:0]]) begin
        sel_idx = k[SISR_IDX_W-1:0];
        sel_valid = 1'b1;
      end
    end
  end

  function automatic logic [7:0] code_of(input logic [SISR_IDX_W-1:0] idx,
                                         input logic [3:0] sc1q, input logic [3:0] sc2,
                                         input logic [1:0] slip);
    case (idx)
      SISR_EV_FAR: code_of = SISR_CODE_FAR;
      SISR_EV_APEND: code_of = SISR_CODE_APEND;
      SISR_EV_ADONE: code_of = SISR_CODE_ADONE;
      SISR_EV_FSLOSS: code_of = SISR_CODE_FSLOSS;
      SISR_EV_DEACT: code_of = SISR_CODE_DEACT;
      SISR_EV_SENT: code_of = SISR_CODE_SENT;
      SISR_EV_COLL: code_of = SISR_CODE_COLL;
      SISR_EV_SC1Q: code_of = {SISR_HI_SC1Q, sc1q};
      SISR_EV_SC2: code_of = {SISR_HI_SC2, sc2};
      SISR_EV_TICK: code_of = SISR_CODE_TICK;
      SISR_EV_FAULT: code_of = SISR_CODE_FAULT;
      SISR_EV_SLIP: begin
        case (slip)
          2'b01: code_of = SISR_CODE_SLIP_TX;
          2'b10: code_of = SISR_CODE_SLIP_RX;
          default: code_of = SISR_CODE_SLIP_BOTH;
        endcase
      end
      default: code_of = SISR_NO_CHANGE_CODE;
    endcase
  endfunction : code_of

  // Transfer tracking: status byte frozen from select low to transfer end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      busy_reg <= 1'b0;
    end else if (!cs_n_sync || start_pulse) begin
      busy_reg <= 1'b1;
    end else if (cs_n_sync) begin
      // Select back high ends the freeze; the done toggle is never seen later than it
      busy_reg <= 1'b0;
    end
  end

  // Pending latches: one per source; set wins over the read clear
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pend_reg <= '0;
      ptr_reg <= '0;
    end else if (i_evt.deactivated_evt) begin
      pend_reg <= '0;
      pend_reg[SISR_EV_DEACT] <= 1'b1;
    end else begin
      for (int i = 0; i < SISR_NUM_EVT; i++) begin
        if (set_vec[i]) begin
          pend_reg[i] <= 1'b1;
        end else if (cmd_pulse && rep_valid_reg && rep_idx_reg == SISR_IDX_W'(i)) begin
          pend_reg[i] <= 1'b0;
        end else if (i == SISR_EV_FAR && cmd_pulse && cmd_word == SISR_WAKE_CMD) begin
          pend_reg[i] <= 1'b0;
        end
      end
      if (cmd_pulse && rep_valid_reg) begin
        ptr_reg <= (rep_idx_reg == SISR_IDX_W'(SISR_NUM_EVT - 1)) ? '0 :
          rep_idx_reg + SISR_IDX_W'(1);
      end
    end
  end

  // Message bits and slip kind: a later event overwrites the earlier one
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sc1q_bits_reg <= 4'h0;
      sc2_bits_reg <= 4'h0;
      slip_kind_reg <= 2'h0;
    end else begin
      if (i_evt.sc1q_msg_rx_evt) begin
        sc1q_bits_reg <= i_evt.message_nibble_bits;
      end
      if (i_evt.sc2_msg_rx_evt) begin
        sc2_bits_reg <= i_evt.message_nibble_bits;
      end
      if (set_vec[SISR_EV_SLIP]) begin
        slip_kind_reg <= {i_evt.slip_rx_evt, i_evt.slip_tx_evt};
      end
    end
  end

  // Status byte presented to the port while idle
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      status_reg <= SISR_NO_CHANGE_CODE;
      rep_valid_reg <= 1'b0;
      rep_idx_reg <= '0;
    end else if (!busy_reg && cs_n_sync && !start_pulse) begin
      rep_valid_reg <= sel_valid;
      rep_idx_reg <= sel_idx;
      if (sel_valid) begin
        status_reg <= code_of(sel_idx, sc1q_bits_reg, sc2_bits_reg, slip_kind_reg);
      end else if (state_out_reg) begin
        status_reg <= {SISR_NO_CHANGE_WITH_STATE_MARK, i_device_state_field, 4'h0};
      end else begin
        status_reg <= SISR_NO_CHANGE_CODE;
      end
    end
  end

  // Interrupt: low only while select is high, released as soon as select goes low
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      int_reg <= 1'b0;
    end else if (start_pulse || !cs_n_sync || busy_reg) begin
      int_reg <= 1'b0;
    end else begin
      int_reg <= rep_valid_reg;
    end
  end

  assign o_int_n = ~(int_reg & i_cs_n);
  assign o_int_n_en = int_reg & i_cs_n;
  assign o_low_power = low_power_reg;
  assign o_extra_events_on = extra_reg;
endmodule : sisr_core

// ==== sim/sisr_core_properties.sv ====
// Port-level checks for the status reporter, bound into the core
`timescale 1ns/10ps
module sisr_core_properties
  import sisr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Watched ports
  input wire logic i_cs_n,
  input wire sisr_pkg::sisr_evt_t i_evt,
  input wire logic o_int_n,
  input wire logic o_int_n_en,
  input wire logic o_status_out_en,
  input wire sisr_pkg::sisr_cmd_t o_cmd,
  input wire logic o_low_power,
  input wire logic o_extra_events_on
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  property p_int_sel;
    !o_int_n |-> i_cs_n;
  endproperty
  a_int_sel: assert property (p_int_sel)
    else $error("interrupt low while selected");
  property p_int_en;
    o_int_n_en == !o_int_n;
  endproperty
  a_int_en: assert property (p_int_en)
    else $error("interrupt enable disagrees with level");
  property p_out_en;
    o_status_out_en == !i_cs_n;
  endproperty
  a_out_en: assert property (p_out_en)
    else $error("status pin drive disagrees with select");
  property p_one_cmd;
    o_cmd.valid |=> !o_cmd.valid;
  endproperty
  a_one_cmd: assert property (p_one_cmd)
    else $error("command valid longer than one cycle");
  property p_lp_set;
    o_cmd.valid && o_cmd.cmd == SISR_LOW_POWER_CMD |-> ##[0:3] o_low_power;
  endproperty
  a_lp_set: assert property (p_lp_set)
    else $error("low power not entered");
  property p_lp_clr;
    o_cmd.valid && o_cmd.cmd == SISR_WAKE_CMD |-> ##[0:3] !o_low_power;
  endproperty
  a_lp_clr: assert property (p_lp_clr)
    else $error("low power not left");
  property p_ext_on;
    o_cmd.valid && o_cmd.cmd == SISR_EXTRA_EVENTS_ON_CMD |-> ##[0:3] o_extra_events_on;
  endproperty
  a_ext_on: assert property (p_ext_on)
    else $error("extra events not enabled");
  property p_ext_off;
    o_cmd.valid && o_cmd.cmd == SISR_EXTRA_EVENTS_OFF_CMD |-> ##[0:3] !o_extra_events_on;
  endproperty
  a_ext_off: assert property (p_ext_off)
    else $error("extra events not disabled");
  property p_int_raise;
    i_evt.activation_done_evt ##1 i_cs_n [*8] ##1 i_cs_n |-> !o_int_n;
  endproperty
  a_int_raise: assert property (p_int_raise)
    else $error("pending event raised no interrupt");

  c_cmd: cover property (o_cmd.valid);
  c_int: cover property (!o_int_n);
  c_lp: cover property (o_low_power);
  c_ext: cover property (o_extra_events_on);
endmodule : sisr_core_properties

bind sisr_core sisr_core_properties u_props (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_cs_n(i_cs_n), .i_evt(i_evt), .o_int_n(o_int_n), .o_int_n_en(o_int_n_en),
  .o_status_out_en(o_status_out_en), .o_cmd(o_cmd), .o_low_power(o_low_power),
  .o_extra_events_on(o_extra_events_on));

// ==== sim/sisr_host_model.sv ====
// Host model driving the serial control port
`timescale 1ns/10ps
module sisr_host_model (
  // Serial pins towards the device
  output logic o_ctl_serial_clock,
  output logic o_cs_n,
  output logic o_cmd_in,
  input wire logic i_status_out
);
  initial begin
    o_ctl_serial_clock = 1'b0;
    o_cs_n = 1'b1;
    o_cmd_in = 1'b1;
  end
  // One byte each way, bit 7 first; clock stands low outside frames
  task automatic xfer(input logic [7:0] cmd, output logic [7:0] st);
    #3 o_cs_n = 1'b0;
    #8;
    for (int i = 7; i >= 0; i--) begin
      o_cmd_in = cmd[i];
      #8 st[i] = i_status_out;
      o_ctl_serial_clock = 1'b1;
      #16 o_ctl_serial_clock = 1'b0;
      #8;
    end
    o_cs_n = 1'b1;
    o_cmd_in = ~o_cmd_in;
  endtask : xfer
endmodule : sisr_host_model

// ==== sim/sisr_core_tb_top.sv ====
// Self-checking bench for the status reporter
`timescale 1ns/10ps
module sisr_core_tb_top;
  import sisr_pkg::*;
  logic i_clk;
  logic i_reset_n;
  logic i_te_mode;
  logic [2:0] i_device_state_field;
  sisr_evt_t i_evt;
  sisr_cmd_t cmd_out;
  logic ctl_clk, cs_n, cmd_in, st_out, st_en, int_n, int_en, low_power, extra_on;
  int n_mismatch;
  int n_tests;
  // Host-side command codes; the message bits are a plain default
  localparam logic [7:0] activation_request_cmd = 8'h03;
  localparam logic [3:0] sc1q_high_tx_write = 4'h4;
  localparam logic [3:0] far_code_viol_bits = 4'h1;

  initial i_clk = 1'b0;
  always #5 i_clk = ~i_clk;

  sisr_core u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ctl_serial_clock(ctl_clk),
    .i_cs_n(cs_n), .i_cmd_in(cmd_in), .o_status_out(st_out), .o_status_out_en(st_en),
    .o_int_n(int_n), .o_int_n_en(int_en), .i_evt(i_evt), .i_te_mode(i_te_mode),
    .i_device_state_field(i_device_state_field), .o_cmd(cmd_out),
    .o_low_power(low_power), .o_extra_events_on(extra_on));
  sisr_host_model u_host (.o_ctl_serial_clock(ctl_clk), .o_cs_n(cs_n), .o_cmd_in(cmd_in),
    .i_status_out(st_out));

  task automatic give_verdict;
    $display("Counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic fail(input string what);
    n_mismatch++;
    $display("ERROR at %0t: %s", $time, what);
    give_verdict();
  endtask : fail

  // One-cycle event pulse, then quiet time with select high
  task automatic pulse(input logic [16:0] v);
    @(negedge i_clk);
    i_evt = sisr_evt_t'(v);
    @(negedge i_clk);
    i_evt = '0;
    repeat (10) @(negedge i_clk);
  endtask : pulse

  task automatic xfer(input logic [7:0] cmd, input logic [7:0] exp, input bit want_int);
    logic [7:0] got;
    int k;
    k = 0;
    while (want_int && int_n !== 1'b0 && k < 40) begin
      @(negedge i_clk);
      k++;
    end
    if (k == 40) fail("no interrupt");
    if (!want_int) chk({7'h0, int_n}, 8'h01, "idle interrupt");
    u_host.xfer(cmd, got);
    k = 0;
    while (cmd_out.valid !== 1'b1 && k < 40) begin
      @(negedge i_clk);
      k++;
    end
    if (k == 40) fail("no command");
    chk(cmd_out.cmd, cmd, "command");
    chk(got, exp, "status");
    repeat (10) @(negedge i_clk);
  endtask : xfer

  task automatic t_codes;
    logic [16:0] ev [8] = '{17'h08000, 17'h04000, 17'h02000, 17'h00800, 17'h00400,
      17'h0020a, 17'h00105, 17'h01000};
    logic [7:0] cd [8] = '{SISR_CODE_APEND, SISR_CODE_ADONE, SISR_CODE_FSLOSS,
      SISR_CODE_SENT, SISR_CODE_COLL, 8'h3a, 8'h55, SISR_CODE_DEACT};
    xfer(SISR_IDLE_CMD, 8'h00, 0);
    for (int i = 0; i < 8; i++) begin
      pulse(ev[i]);
      xfer(SISR_IDLE_CMD, cd[i], 1);
      if (i == 0) xfer(activation_request_cmd, 8'h00, 0);
    end
    xfer(SISR_SENT_OFF_CMD, 8'h00, 0);
    pulse(17'h00800);
    xfer(SISR_IDLE_CMD, 8'h00, 0);
    xfer(SISR_SENT_ON_CMD, 8'h00, 0);
    $display("Test codes done");
  endtask : t_codes

  task automatic t_far_extra;
    pulse(17'h10000);
    xfer(SISR_IDLE_CMD, 8'h00, 0);
    xfer(SISR_LOW_POWER_CMD, 8'h00, 0);
    chk({7'h0, low_power}, 8'h01, "low power flag");
    pulse(17'h10000);
    xfer(SISR_IDLE_CMD, SISR_CODE_FAR, 1);
    xfer(SISR_WAKE_CMD, 8'h00, 0);
    chk({7'h0, low_power}, 8'h00, "awake flag");
    pulse(17'h00040);
    xfer(SISR_IDLE_CMD, 8'h00, 0);
    xfer(SISR_EXTRA_EVENTS_ON_CMD, 8'h00, 0);
    chk({7'h0, extra_on}, 8'h01, "extra events flag");
    pulse(17'h00040);
    xfer(SISR_IDLE_CMD, SISR_CODE_FAULT, 1);
    xfer({sc1q_high_tx_write, far_code_viol_bits}, 8'h00, 0);
    pulse(17'h00020);
    xfer(SISR_IDLE_CMD, SISR_CODE_SLIP_TX, 1);
    pulse(17'h00010);
    xfer(SISR_IDLE_CMD, SISR_CODE_SLIP_RX, 1);
    pulse(17'h00030);
    xfer(SISR_IDLE_CMD, SISR_CODE_SLIP_BOTH, 1);
    xfer(SISR_EXTRA_EVENTS_OFF_CMD, 8'h00, 0);
    chk({7'h0, extra_on}, 8'h00, "extra events flag off");
    $display("Test far end and extra events done");
  endtask : t_far_extra

  task automatic t_modes;
    xfer(SISR_TICK_5MS_ON_CMD, 8'h00, 0);
    pulse(17'h00080);
    xfer(SISR_IDLE_CMD, SISR_CODE_TICK, 1);
    xfer(SISR_TICK_5MS_OFF_CMD, 8'h00, 0);
    pulse(17'h00080);
    xfer(SISR_IDLE_CMD, 8'h00, 0);
    xfer(SISR_TICK_30MS_ON_CMD, 8'h00, 0);
    repeat (6) pulse(17'h00080);
    xfer(SISR_IDLE_CMD, SISR_CODE_TICK, 1);
    pulse(17'h00080);
    xfer(SISR_IDLE_CMD, 8'h00, 0);
    xfer(SISR_TICK_30MS_OFF_CMD, 8'h00, 0);
    xfer(SISR_STATE_OUT_ON_CMD, 8'h00, 0);
    xfer(SISR_IDLE_CMD, 8'hd0, 0);
    xfer(SISR_STATE_OUT_OFF_CMD, 8'hd0, 0);
    xfer(SISR_IDLE_CMD, 8'h00, 0);
    $display("Test modes done");
  endtask : t_modes

  task automatic t_overwrite;
    pulse(17'h00201);
    pulse(17'h00202);
    xfer(SISR_IDLE_CMD, 8'h32, 1);
    xfer(SISR_IDLE_CMD, 8'h00, 0);
    pulse(17'h08000);
    pulse(17'h04000);
    pulse(17'h01000);
    xfer(SISR_IDLE_CMD, SISR_CODE_DEACT, 1);
    xfer(SISR_IDLE_CMD, 8'h00, 0);
    // Scan resumes after the last reported source, not at the lowest index
    pulse(17'h08000);
    pulse(17'h00400);
    xfer(SISR_IDLE_CMD, SISR_CODE_COLL, 1);
    xfer(SISR_IDLE_CMD, SISR_CODE_APEND, 1);
    $display("Test overwrite and clear done");
  endtask : t_overwrite

  initial begin
    n_mismatch = 0;
    n_tests = 0;
    i_reset_n = 1'b0;
    i_evt = '0;
    i_te_mode = 1'b1;
    i_device_state_field = 3'h5;
    repeat (20) @(negedge i_clk);
    i_reset_n = 1'b1;
    repeat (6) @(negedge i_clk);
    t_codes();
    t_far_extra();
    t_modes();
    t_overwrite();
    give_verdict();
  end
endmodule : sisr_core_tb_top
